// >>> common/nco_phase_pkg.sv
package nco_phase_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 12;
	localparam int          DATA_W       = 32;
	localparam int          IDX_W        = 10;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_CHAN1_PHASE_OFFSET_LOW  = 10'h088;
	localparam logic [IDX_W-1:0] IDX_CHAN1_PHASE_OFFSET_HIGH = 10'h089;
	localparam logic [IDX_W-1:0] IDX_CHAN2_PHASE_OFFSET_LOW  = 10'h08A;
	localparam logic [IDX_W-1:0] IDX_CHAN2_PHASE_OFFSET_HIGH = 10'h08B;
	localparam logic [IDX_W-1:0] IDX_CHAN3_PHASE_OFFSET_LOW  = 10'h08C;
	localparam logic [IDX_W-1:0] IDX_CHAN3_PHASE_OFFSET_HIGH = 10'h08D;
	localparam logic [IDX_W-1:0] IDX_CHAN4_PHASE_OFFSET_LOW  = 10'h08E;
	localparam logic [IDX_W-1:0] IDX_CHAN4_PHASE_OFFSET_HIGH = 10'h08F;
	localparam logic [IDX_W-1:0] IDX_MODE_CTRL               = 10'h070;
	localparam logic [IDX_W-1:0] IDX_PHASE_STATUS            = 10'h071;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_DDC_BIT     = 0;
	localparam int          CTRL_MODE_LSB    = 1;
	localparam int          CTRL_CW_BIT      = 3;
	localparam int          STAT_ACTIVE_BIT  = 0;
	localparam logic [7:0]  PHASE_BYTE_RESET = 8'h00;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam logic [3:0]  CTRL_WR_MASK     = 4'hF;

	// ----------------------------------------------------------------
	// Datapath geometry
	// ----------------------------------------------------------------
	localparam int          PHASE_W    = 16;
	localparam int          ACC_W      = 32;
	localparam int          SEQ_POS_W  = 3;
	localparam int          SLOT_COUNT = 4;
	localparam int          BYTE_COUNT = 8;
	localparam logic [2:0]  FIRST_SLOT_POS = 3'h1;
	localparam logic [2:0]  LAST_SLOT_POS  = 3'h4;

	typedef enum logic [1:0] {
		CHAN_MODE_SINGLE = 2'h0,
		CHAN_MODE_DUAL   = 2'h1,
		CHAN_MODE_OCTAL  = 2'h2,
		CHAN_MODE_RSVD   = 2'h3
	} chan_mode_t;

	typedef enum logic [1:0] {
		RD_IDLE  = 2'h0,
		RD_FETCH = 2'h1,
		RD_RESP  = 2'h3
	} rd_state_t;

endpackage

// >>> design/nco_channel_phase_offset_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - Two bytes form each 16-bit phase word
// - Phase words reset to zero, zero degrees
// - Word 0x00FF gives about 1.4 degrees
// - Word 0xFFFF gives 359.995 degrees, linear
// - Slot n drives sequence position n+1
// - Offsets only in DDC or CW-DDC modes
module nco_channel_phase_offset_regs
	import nco_phase_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 srst_in,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [DATA_W-1:0]    s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [DATA_W-1:0]         s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	output logic                      s_axi_rready_unused_out,
	input  wire logic                 s_axi_rready_in,
	input  wire logic [ACC_W-1:0]     accum_phase_in,
	input  wire logic [SEQ_POS_W-1:0] seq_position_in,
	input  wire logic                 sample_valid_in,
	output logic [PHASE_W-1:0]        mix_phase_out,
	output logic                      mix_valid_out,
	output logic                      phase_active_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic               aw_held;
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_held;
		logic [7:0]         w_byte;
		logic               w_lane0;
		logic               awready;
		logic               wready;
		logic               bvalid;
		logic [1:0]         bresp;
		rd_state_t          rd;
		logic [ADDR_W-1:0]  ar_addr;
		logic               arready;
		logic               rvalid;
		logic [DATA_W-1:0]  rdata;
		logic [1:0]         rresp;
		logic [7:0]         ctrl;
		logic [PHASE_W-1:0] mix;
		logic               mix_valid;
		logic               active;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	logic                          mem_wr_en;
	logic [2:0]                    mem_wr_addr;
	logic [7:0]                    mem_wr_data;
	logic                          mem_rd_en;
	logic [2:0]                    mem_rd_addr;
	logic [7:0]                    mem_rd_data;
	logic [BYTE_COUNT*8-1:0]       phase_bytes;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic aligned(input logic [ADDR_W-1:0] a);
		return a[1:0] == 2'h0;
	endfunction

	function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

	function automatic logic is_phase(input logic [ADDR_W-1:0] a);
		return aligned(a) && reg_index(a) >= IDX_CHAN1_PHASE_OFFSET_LOW
			&& reg_index(a) <= IDX_CHAN4_PHASE_OFFSET_HIGH;
	endfunction

	function automatic logic [2:0] byte_slot(input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] d;
		d = reg_index(a) - IDX_CHAN1_PHASE_OFFSET_LOW;
		return d[2:0];
	endfunction

	function automatic logic is_index(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
		return aligned(a) && reg_index(a) == idx;
	endfunction

	// Offsets count only in CW with DDC in octal mode, or single/dual with DDC
	function automatic logic offsets_live(input logic [7:0] c);
		chan_mode_t m;
		m = chan_mode_t'(c[CTRL_MODE_LSB +: 2]);
		return c[CTRL_DDC_BIT] && ((m == CHAN_MODE_OCTAL && c[CTRL_CW_BIT])
			|| m == CHAN_MODE_SINGLE || m == CHAN_MODE_DUAL);
	endfunction

	// Low byte of slot k sits below its high byte
	function automatic logic [PHASE_W-1:0] slot_word(input logic [BYTE_COUNT*8-1:0] b, input logic [2:0] pos);
		logic [2:0] k;
		k = pos - FIRST_SLOT_POS;
		return {b[(2*k+1)*8 +: 8], b[(2*k)*8 +: 8]};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [PHASE_W-1:0] offs;
		offs        = '0;
		s_nxt       = s_r;
		mem_wr_en   = 1'b0;
		mem_wr_addr = byte_slot(s_r.aw_addr);
		mem_wr_data = s_r.w_byte;
		mem_rd_en   = 1'b0;
		mem_rd_addr = byte_slot(s_axi_araddr_in);

		// Address and data are taken independently, in either order
		if (s_r.awready && s_axi_awvalid_in) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr_in;
		end
		if (s_r.wready && s_axi_wvalid_in) begin
			s_nxt.w_held  = 1'b1;
			s_nxt.w_byte  = s_axi_wdata_in[7:0];
			s_nxt.w_lane0 = s_axi_wstrb_in[0];
		end

		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.bresp = RESP_OKAY;
			if (is_phase(s_r.aw_addr)) begin
				mem_wr_en = s_r.w_lane0;
			end else if (is_index(s_r.aw_addr, IDX_MODE_CTRL)) begin
				if (s_r.w_lane0) begin
					s_nxt.ctrl = s_r.w_byte & {4'h0, CTRL_WR_MASK};
				end
			end else if (!is_index(s_r.aw_addr, IDX_PHASE_STATUS)) begin
				s_nxt.bresp = RESP_SLVERR;
			end
			s_nxt.bvalid  = 1'b1;
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
		end else if (s_r.bvalid && s_axi_bready_in) begin
			s_nxt.bvalid = 1'b0;
		end
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

		// Reads: one cycle in the byte store, then the answer
		case (s_r.rd)
			RD_IDLE: begin
				if (s_r.arready && s_axi_arvalid_in) begin
					s_nxt.ar_addr = s_axi_araddr_in;
					mem_rd_en     = is_phase(s_axi_araddr_in);
					s_nxt.rd      = RD_FETCH;
				end
			end
			RD_FETCH: begin
				s_nxt.rresp = RESP_OKAY;
				if (is_phase(s_r.ar_addr)) begin
					s_nxt.rdata = {24'h000000, mem_rd_data};
				end else if (is_index(s_r.ar_addr, IDX_MODE_CTRL)) begin
					s_nxt.rdata = {24'h000000, s_r.ctrl};
				end else if (is_index(s_r.ar_addr, IDX_PHASE_STATUS)) begin
					s_nxt.rdata = '0;
					s_nxt.rdata[STAT_ACTIVE_BIT] = s_r.active;
				end else begin
					s_nxt.rdata = '0;
					s_nxt.rresp = RESP_SLVERR;
				end
				s_nxt.rvalid = 1'b1;
				s_nxt.rd     = RD_RESP;
			end
			RD_RESP: begin
				if (s_axi_rready_in) begin
					s_nxt.rvalid = 1'b0;
					s_nxt.rd     = RD_IDLE;
				end
			end
			default: begin
				s_nxt.rvalid = 1'b0;
				s_nxt.rd     = RD_IDLE;
			end
		endcase
		s_nxt.arready = s_nxt.rd == RD_IDLE;

		// ------------------------------------------------------------
		// Mixing phase
		// ------------------------------------------------------------
		s_nxt.active = offsets_live(s_r.ctrl);
		if (s_r.active && seq_position_in >= FIRST_SLOT_POS && seq_position_in <= LAST_SLOT_POS) begin
			offs = slot_word(phase_bytes, seq_position_in);
		end
		// Full 16-bit circle equals 360 degrees, so the scale is linear:
		// 0x0000 is 0, 0x00FF about 1.4 and 0xFFFF 359.995 degrees
		s_nxt.mix       = accum_phase_in[ACC_W-1 -: PHASE_W] + offs;
		s_nxt.mix_valid = sample_valid_in;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_r      <= '0;
			s_r.ctrl <= CTRL_RESET;
			s_r.rd   <= RD_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Phase byte storage
	// ----------------------------------------------------------------
	phase_byte_store #(
		.DEPTH (BYTE_COUNT),
		.W     (8)
	) u_store (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.wr_en_in    (mem_wr_en),
		.wr_addr_in  (mem_wr_addr),
		.wr_data_in  (mem_wr_data),
		.rd_en_in    (mem_rd_en),
		.rd_addr_in  (mem_rd_addr),
		.rd_data_out (mem_rd_data),
		.bytes_out   (phase_bytes)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_out       = s_r.awready;
	assign s_axi_wready_out        = s_r.wready;
	assign s_axi_bresp_out         = s_r.bresp;
	assign s_axi_bvalid_out        = s_r.bvalid;
	assign s_axi_arready_out       = s_r.arready;
	assign s_axi_rdata_out         = s_r.rdata;
	assign s_axi_rresp_out         = s_r.rresp;
	assign s_axi_rvalid_out        = s_r.rvalid;
	assign s_axi_rready_unused_out = s_r.mix_valid & 1'b0;
	assign mix_phase_out           = s_r.mix;
	assign mix_valid_out           = s_r.mix_valid;
	assign phase_active_out        = s_r.active;

endmodule // nco_channel_phase_offset_regs

// >>> design/phase_byte_store.sv
`timescale 1ns/10ps
module phase_byte_store
	import nco_phase_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int W     = 8
) (
	input  wire logic                         clk_in,
	input  wire logic                         srst_in,
	input  wire logic                         wr_en_in,
	input  wire logic [$clog2(DEPTH)-1:0]     wr_addr_in,
	input  wire logic [W-1:0]                 wr_data_in,
	input  wire logic                         rd_en_in,
	input  wire logic [$clog2(DEPTH)-1:0]     rd_addr_in,
	output logic      [W-1:0]                 rd_data_out,
	output logic      [DEPTH*W-1:0]           bytes_out
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0]            rd;
	} store_t;

	store_t s_r;
	store_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (wr_en_in) begin
			s_nxt.mem[wr_addr_in] = wr_data_in;
		end
		if (rd_en_in) begin
			s_nxt.rd = s_r.mem[rd_addr_in];
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data_out = s_r.rd;
	assign bytes_out   = s_r.mem;

endmodule // phase_byte_store

// >>> tb/nco_channel_phase_offset_regs_bench.sv
`timescale 1ns/10ps
module nco_channel_phase_offset_regs_bench
	import nco_phase_pkg::*;
;
	localparam logic [7:0] PV [8] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h34, 8'h12, 8'h01, 8'h80};
	// Quarter turn as the host programs it: 2^16 * degrees / 360
	localparam int         QUARTER_WORD = (65536 * 90) / 360;
	logic                 clk_in = 1'b0;
	logic                 srst_in = 1'b1;
	logic [ADDR_W-1:0]    s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
	logic [DATA_W-1:0]    s_axi_wdata_in = 32'h00000000, s_axi_rdata_out;
	logic [3:0]           s_axi_wstrb_in = 4'h0;
	logic [1:0]           s_axi_bresp_out, s_axi_rresp_out;
	logic                 s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic                 s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic                 s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [ACC_W-1:0]     accum_phase_in = 32'h00000000;
	logic [SEQ_POS_W-1:0] seq_position_in = 3'h0;
	logic                 sample_valid_in = 1'b0;
	logic [PHASE_W-1:0]   mix_phase_out;
	logic                 mix_valid_out, phase_active_out, s_axi_rready_unused_out;
	int                   n_errors = 0, samples_checked = 0;

	nco_channel_phase_offset_regs nco_channel_phase_offset_regs_i (
		.clk_in, .srst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
		.s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_unused_out, .s_axi_rready_in,
		.accum_phase_in, .seq_position_in, .sample_valid_in, .mix_phase_out, .mix_valid_out,
		.phase_active_out);

	always #25 clk_in = ~clk_in;

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge clk_in);
		n++;
		if (n > 64) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	function automatic logic [ADDR_W-1:0] baddr(input int k);
		return {IDX_CHAN1_PHASE_OFFSET_LOW + IDX_W'(k), 2'h0};
	endfunction
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		int n = 0;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h000000, d};
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			tick(n);
			if (s_axi_awvalid_in && s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp_out}, {30'h0, er});
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n = 0;
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			tick(n);
			if (s_axi_arvalid_in && s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		check("rdata", s_axi_rdata_out, {24'h000000, ed});
		check("rresp", {30'h0, s_axi_rresp_out}, {30'h0, er});
	endtask
	task automatic mix(input logic [2:0] p, input logic [15:0] hi, input logic [15:0] exp);
		@(posedge clk_in);
		accum_phase_in <= {hi, 16'h5A5A};
		seq_position_in <= p;
		sample_valid_in <= 1'b1;
		@(posedge clk_in);
		sample_valid_in <= 1'b0;
		#1;
		check("mix", {16'h0000, mix_phase_out}, {16'h0000, exp});
		check("mix_valid", {31'h0, mix_valid_out}, 32'h1);
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic sc_reset();
		for (int k = 0; k < BYTE_COUNT; k++) rd(baddr(k), 8'h00, RESP_OKAY);
		check("active", {31'h0, phase_active_out}, 32'h0);
		check("spare", {31'h0, s_axi_rready_unused_out}, 32'h0);
	endtask
	// Reset in mid-run must clear every byte and the mode again
	task automatic sc_rerun();
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		sc_reset();
	endtask
	task automatic sc_rw();
		for (int k = 0; k < BYTE_COUNT; k++) wr(baddr(k), PV[k], 4'h1, RESP_OKAY);
		// Lane zero off must leave the byte alone
		wr(baddr(0), 8'h11, 4'hE, RESP_OKAY);
		for (int k = 0; k < BYTE_COUNT; k++) rd(baddr(k), PV[k], RESP_OKAY);
	endtask
	task automatic sc_errs();
		rd(12'h300, 8'h00, RESP_SLVERR);
		wr(12'h300, 8'h5A, 4'h1, RESP_SLVERR);
		rd(baddr(0) + 12'h001, 8'h00, RESP_SLVERR);
		rd(baddr(1), PV[1], RESP_OKAY);
	endtask
	task automatic sc_slots();
		wr({IDX_MODE_CTRL, 2'h0}, 8'h0D, 4'h1, RESP_OKAY);
		// Sums wrap modulo 2^16, so the large slot words also exercise the carry out
		for (int p = 0; p < 8; p++) begin
			mix(3'(p), 16'hF000, (p > 0 && p < 5) ? 16'hF000 + {PV[2*p-1], PV[2*p-2]} : 16'hF000);
		end
		wr(baddr(4), 8'(QUARTER_WORD), 4'h1, RESP_OKAY);
		wr(baddr(5), 8'(QUARTER_WORD >> 8), 4'h1, RESP_OKAY);
		mix(3'h3, 16'h1000, 16'h1000 + 16'(QUARTER_WORD));
	endtask
	task automatic sc_modes();
		logic [7:0] m [7] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h0D, 8'h07, 8'h0C};
		logic       e [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		for (int k = 0; k < 7; k++) begin
			wr({IDX_MODE_CTRL, 2'h0}, m[k], 4'h1, RESP_OKAY);
			#1;
			check("active", {31'h0, phase_active_out}, {31'h0, e[k]});
			rd({IDX_PHASE_STATUS, 2'h0}, {7'h00, e[k]}, RESP_OKAY);
			mix(3'h2, 16'h0101, e[k] ? 16'h0100 : 16'h0101);
		end
	endtask

	initial begin
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		sc_reset();
		sc_rw();
		sc_errs();
		sc_slots();
		sc_modes();
		sc_rerun();
		tally_and_finish();
	end
endmodule // nco_channel_phase_offset_regs_bench

// >>> tb/nco_phase_props.sv
`timescale 1ns/10ps
module nco_phase_props
	import nco_phase_pkg::*;
(
	input wire logic                 clk_in,
	input wire logic                 srst_in,
	input wire logic                 s_axi_awvalid_in,
	input wire logic                 s_axi_awready_out,
	input wire logic                 s_axi_wvalid_in,
	input wire logic                 s_axi_wready_out,
	input wire logic                 s_axi_bvalid_out,
	input wire logic                 s_axi_arvalid_in,
	input wire logic                 s_axi_arready_out,
	input wire logic                 s_axi_rvalid_out,
	input wire logic [DATA_W-1:0]    s_axi_rdata_out,
	input wire logic [1:0]           s_axi_rresp_out,
	input wire logic [ACC_W-1:0]     accum_phase_in,
	input wire logic [SEQ_POS_W-1:0] seq_position_in,
	input wire logic                 sample_valid_in,
	input wire logic [PHASE_W-1:0]   mix_phase_out,
	input wire logic                 mix_valid_out,
	input wire logic                 phase_active_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// ------------------------------------------------
	// Register bus
	// ------------------------------------------------
	a_aw_drop: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
		else $error("awready not dropped");
	a_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##[1:2] s_axi_bvalid_out) else $error("write answer late");
	a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[2:3] s_axi_rvalid_out)
		else $error("read answer late");
	a_err_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR
		|-> s_axi_rdata_out == 32'h00000000) else $error("error read carries data");
	a_byte_wide: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
		else $error("read data above byte");
	// ------------------------------------------------
	// Mixing path
	// ------------------------------------------------
	a_valid_follow: assert property (1'b1 |=> mix_valid_out == $past(sample_valid_in))
		else $error("mix valid not one cycle behind");
	// Two quiet cycles, since the gate may be taken from the control byte or its registered copy
	a_gate_off: assert property (!phase_active_out ##1 !phase_active_out
		|-> {16'h0000, mix_phase_out} == ($past(accum_phase_in) >> 16)) else $error("offset while inactive");
	a_other_pos: assert property (seq_position_in < FIRST_SLOT_POS || seq_position_in > LAST_SLOT_POS
		|=> {16'h0000, mix_phase_out} == ($past(accum_phase_in) >> 16)) else $error("offset outside slots");
endmodule // nco_phase_props

bind nco_channel_phase_offset_regs nco_phase_props nco_phase_props_i (
	.clk_in, .srst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rdata_out,
	.s_axi_rresp_out, .accum_phase_in, .seq_position_in, .sample_valid_in, .mix_phase_out,
	.mix_valid_out, .phase_active_out);
